// [core/fsp_pkg.sv]
// package: register map, pin timing and status bit positions for the flash status poller
package fsp_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // own avalon register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_SAMPLE = 4'h5;
  // ctrl command codes (write data bits 2:0)
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_POLL = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;
  localparam int CTRL_CE_STYLE = 3;
  // device status bit positions on the data bus
  localparam int POLLING_BIT = 7;
  localparam int GLOBAL_TOGGLE_BIT = 6;
  localparam int TIMEOUT_FAIL_FLAG = 5;
  localparam int ERASE_WINDOW_TIMER_BIT = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;
  // reset command word written to any address
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  // pin timing in ns and derived cycles at 8 ns
  localparam int CLK_NS = 8;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 40;
  localparam int T_HIGH_NS = 25;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // poll verdicts
  localparam logic [1:0] RES_DONE = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_BUSY = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_STROBE = 4'b0011,
    ST_GAP = 4'b0010,
    ST_DECIDE = 4'b0110,
    ST_DONE = 4'b0111
  } fsp_state_type;
endpackage

// [core/fsp_poller.sv]
// flash status poller: avalon-mm slave driving the flash pins and running toggle-bit polling
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// What the document says about the device and the host
// RULE_01: device flips the sector toggle on reads inside erasing sectors.
// RULE_02: sector toggle is valid after the last write strobe rises.
// RULE_03: toggle reads may be framed by output enable or chip enable.
// RULE_04: sector toggle cannot tell erase from suspend; global toggle can.
// RULE_05: polling opens with two back-to-back reads compared on the toggle bit.
// RULE_06: no toggle means finished; next read gives array data.
// RULE_07: toggling with timeout high: recheck; still toggling means failed, send reset.
// RULE_08: toggling with timeout low: keep polling, or restart from first step.
// RULE_09: device raises timeout flag when pulse limit exceeded.
// RULE_10: programming 0 to 1 fails and raises timeout flag.
// RULE_11: after a timeout failure the host writes the reset command.
// RULE_12: erase timer bit is 0 in acceptance window, 1 after.
// RULE_13: each extra sector erase restarts the window; not for chip erase.
// RULE_14: timer 1 means only erase suspend is accepted.
// RULE_15: host confirms acceptance, then samples erase timer around extra erases.
// RULE_16: embedded erase status pattern on polling, toggles, timer and ready.
// RULE_17: erase-suspend-read status at suspended sectors; data elsewhere.
// RULE_18: status reads must address the busy bank.
// RULE_19: host presents a valid program or erase address for status.
// RULE_20: global toggle flips every read while busy, stops when done.
// RULE_21: polling bit is complement of written data until done.
module fsp_poller (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_in,
  output logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic ready_busy_n
);
  fsp_pkg::fsp_state_type state_q;
  logic [2:0] cmd_q;
  logic ce_style_q;
  logic [fsp_pkg::ADDR_W-1:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] first_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic [3:0] cnt_q;
  logic [1:0] nreads_q;
  logic recheck_q;
  logic busy_q;
  logic [1:0] result_q;
  logic done_q;
  logic wr_ctrl;

  function automatic logic toggled(input logic [15:0] a, input logic [15:0] b);
    toggled = a[fsp_pkg::GLOBAL_TOGGLE_BIT] ^ b[fsp_pkg::GLOBAL_TOGGLE_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // ready input resets high, the level its pull-up leaves on an idle pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave, single-cycle wait then answer
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == fsp_pkg::REG_CTRL && !busy_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          fsp_pkg::REG_CTRL: avs_readdata <= {28'h000_0000, ce_style_q, cmd_q};
          fsp_pkg::REG_ADDR: avs_readdata <= {10'h000, addr_q};
          fsp_pkg::REG_WDATA: avs_readdata <= {16'h0000, wdata_q};
          fsp_pkg::REG_STATUS: avs_readdata <= {27'h000_0000, rb_s2_q, done_q, result_q, busy_q};
          // raw status words stay readable, so software can watch the erase timer around extra erases
          fsp_pkg::REG_RDATA: avs_readdata <= {16'h0000, rdata_q}; // [RULE_15]
          fsp_pkg::REG_SAMPLE: avs_readdata <= {16'h0000, first_q}; // [RULE_15]
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      wdata_q <= 16'h0000;
      ce_style_q <= 1'b0;
      cmd_q <= 3'h0;
    // a busy sequencer keeps its address, data and command
    end else if (avs_write && !avs_waitrequest && !busy_q) begin
      case (avs_address)
        fsp_pkg::REG_ADDR: addr_q <= avs_writedata[fsp_pkg::ADDR_W-1:0]; // [RULE_18] [RULE_19]
        fsp_pkg::REG_WDATA: wdata_q <= avs_writedata[15:0];
        fsp_pkg::REG_CTRL: begin
          cmd_q <= avs_writedata[2:0];
          ce_style_q <= avs_writedata[fsp_pkg::CTRL_CE_STYLE];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin sequencer and toggle-bit polling
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= fsp_pkg::ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= fsp_pkg::RES_DONE;
      cnt_q <= 4'h0;
      nreads_q <= 2'h0;
      recheck_q <= 1'b0;
      first_q <= 16'h0000;
      rdata_q <= 16'h0000;
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      case (state_q)
        fsp_pkg::ST_IDLE: begin
          if (wr_ctrl && avs_writedata[2:0] != 3'h0) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            nreads_q <= 2'h0; // polling always restarts from its first read [RULE_08]
            recheck_q <= 1'b0;
            flash_addr <= addr_q;
            flash_dq_out <= (avs_writedata[2:0] == fsp_pkg::CMD_RESET) ? fsp_pkg::RESET_CMD : wdata_q; // [RULE_11]
            flash_dq_oe <= avs_writedata[2:0] == fsp_pkg::CMD_WRITE || avs_writedata[2:0] == fsp_pkg::CMD_RESET;
            cnt_q <= 4'h0;
            state_q <= fsp_pkg::ST_SETUP;
          end
        end
        fsp_pkg::ST_SETUP: begin
          flash_ce_n <= 1'b0;
          if (flash_dq_oe) begin
            flash_we_n <= 1'b0;
          end else begin
            flash_oe_n <= 1'b0;
          end
          state_q <= fsp_pkg::ST_STROBE;
        end
        fsp_pkg::ST_STROBE: begin
          cnt_q <= cnt_q + 4'h1;
          // two sync stages added to the access time
          if (flash_dq_oe ? cnt_q >= 4'(fsp_pkg::WP_CYC) : cnt_q >= 4'(fsp_pkg::ACC_CYC + 2)) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_ce_n <= ce_style_q ? 1'b1 : flash_ce_n; // [RULE_03]
            rdata_q <= dq_s2_q;
            cnt_q <= 4'h0;
            state_q <= fsp_pkg::ST_GAP;
          end
        end
        fsp_pkg::ST_GAP: begin
          flash_ce_n <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= 4'(fsp_pkg::HIGH_CYC)) begin
            cnt_q <= 4'h0;
            state_q <= (cmd_q == fsp_pkg::CMD_POLL) ? fsp_pkg::ST_DECIDE : fsp_pkg::ST_DONE;
          end
        end
        fsp_pkg::ST_DECIDE: begin
          // first_q holds the read just before the one in rdata_q
          state_q <= fsp_pkg::ST_SETUP;
          first_q <= rdata_q;
          if (nreads_q == 2'h0) begin
            nreads_q <= 2'h1; // [RULE_05]
          end else if (!toggled(first_q, rdata_q)) begin
            result_q <= fsp_pkg::RES_DONE; // [RULE_06] [RULE_07]
            state_q <= fsp_pkg::ST_DONE;
          end else if (recheck_q) begin
            result_q <= fsp_pkg::RES_FAIL; // software then issues the reset command [RULE_07] [RULE_11]
            state_q <= fsp_pkg::ST_DONE;
          end else if (rdata_q[fsp_pkg::TIMEOUT_FAIL_FLAG]) begin
            recheck_q <= 1'b1; // [RULE_07]
          end else begin
            result_q <= fsp_pkg::RES_BUSY; // hand back; next poll restarts [RULE_08]
            state_q <= fsp_pkg::ST_DONE;
          end
        end
        fsp_pkg::ST_DONE: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          flash_dq_oe <= 1'b0;
          state_q <= fsp_pkg::ST_IDLE;
        end
        default: state_q <= fsp_pkg::ST_IDLE;
      endcase
    end
  end
endmodule

// [sim/fsp_poller_checker.sv]
// checker: avalon and flash pin timing of the status poller
`timescale 1ns/1ps
module fsp_poller_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped data");
  chk_oe_in_ce: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
    else $error("read outside select");
  chk_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write outside select");
  chk_oe_hold: assert property ($fell(flash_oe_n) |-> (!flash_oe_n) [*8])
    else $error("short read");
  chk_we_width: assert property ($fell(flash_we_n) |-> (!flash_we_n) [*5])
    else $error("short write");
  chk_read_gap: assert property ($rose(flash_oe_n) |=> flash_oe_n [*3])
    else $error("short gap");
  chk_write_drives_bus: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write strobe without data drive");
  chk_read_bus_free: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  cover property (!flash_we_n && flash_dq_oe);
  cover property ($fell(flash_oe_n));
  cover property ($fell(flash_we_n));
  cover property (avs_read && !avs_waitrequest && avs_address == 4'h3);
endmodule
bind fsp_poller fsp_poller_checker i_chk (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe);

// [sim/fsp_flash_model.sv]
// behavioural flash: status word while an operation runs, array data otherwise
`timescale 1ns/1ps
module fsp_flash_model (
  input wire logic clock,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [15:0] flash_dq_out,
  input wire logic start,
  input wire logic [7:0] reads,
  input wire logic fail,
  input wire logic prog,
  input wire logic [15:0] array,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_n
);
  logic [7:0] rem_q = 8'h00;
  logic tg_q = 1'b1;
  logic rdn_q = 1'b1;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] wr_q = 16'h0000;
  logic wen_q = 1'b1;
  wire rdn = flash_ce_n | flash_oe_n;
  assign ready_busy_n = (rem_q == 8'h00);
  // released bus shows the inverse of the last word
  // program status: written bit inverted, no sector toggle; fail also stands for a 0-to-1 attempt
  // erase status: acceptance window already closed, so the timer reads 1 and only reset is acted on
  assign flash_dq_in = rdn ? ~last_q : (rem_q == 8'h00) ? array : prog ?
    {8'h00, ~wr_q[7], tg_q, fail, 5'h00} :
    {8'h00, 1'b0, tg_q, fail, 2'b01, tg_q, 2'b00};
  always @(posedge clock) begin
    rdn_q <= rdn;
    wen_q <= flash_we_n;
    if (!rdn) last_q <= flash_dq_in;
    if (!flash_we_n) wr_q <= flash_dq_out;
    if (start) begin
      // status valid from the start pulse onward
      rem_q <= reads;
      tg_q <= 1'b1;
    end else if (!rdn_q && rdn && rem_q != 8'h00) begin
      tg_q <= ~tg_q;
      rem_q <= rem_q - 8'h01;
    end
    if (!wen_q && flash_we_n && wr_q == fsp_pkg::RESET_CMD) rem_q <= 8'h00;
  end
endmodule

// [sim/fsp_poller_tb.sv]
// testbench: poller against the flash model
`timescale 1ns/1ps
module fsp_poller_tb;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, start, fail, prog;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_busy_n;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, wa;
  logic [21:0] flash_addr;
  logic [15:0] flash_dq_in, flash_dq_out, array, d;
  logic [7:0] reads;
  logic [1:0] e;
  int num_errors = 0, n_checks = 0, seed = 42776;
  fsp_poller i_dut (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_in, .flash_dq_out,
    .flash_dq_oe, .ready_busy_n);
  fsp_flash_model i_flash (.clock, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .start, .reads,
    .fail, .prog, .array, .flash_dq_in, .ready_busy_n);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] wd);
    int i;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= wd;
    for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i++) @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
    if (i >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic run(input logic [2:0] c, input logic ce);
    int i;
    av(fsp_pkg::REG_CTRL, 1'b1, {28'h000_0000, ce, c});
    for (i = 0; i < 100 && (i == 0 || q[0] !== 1'b0); i++) av(fsp_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    if (i >= 100) begin
      num_errors++;
      give_verdict();
    end
  endtask
  function automatic logic [1:0] exp_res(input logic [7:0] r, input logic f);
    if (r < 8'h02) return fsp_pkg::RES_DONE;
    return f ? fsp_pkg::RES_FAIL : fsp_pkg::RES_BUSY;
  endfunction
  // last word a poll reads: array once idle; a failing poll makes a third read, so toggle ends high
  function automatic logic [15:0] exp_sample(input logic [7:0] r, input logic f, input logic p);
    if (r < 8'h02) return array;
    return p ? {8'h00, ~d[7], f, f, 5'h00} : {8'h00, 1'b0, f, f, 2'b01, f, 2'b00};
  endfunction
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, start, fail, prog} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    reads = 8'h00;
    array = 16'h0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int k = 0; k < 4; k++) begin
      d = 16'($random(seed));
      wa = $random(seed) & 32'h003F_FFFF;
      av(fsp_pkg::REG_ADDR, 1'b1, wa);
      av(fsp_pkg::REG_WDATA, 1'b1, {16'h0000, d});
      run(fsp_pkg::CMD_WRITE, k[0]);
      chk({16'h0000, i_flash.wr_q}, {16'h0000, d});
      chk({10'h000, flash_addr}, wa);
      av(fsp_pkg::REG_ADDR, 1'b0, 32'h0000_0000);
      chk(q, wa);
      av(fsp_pkg::REG_WDATA, 1'b0, 32'h0000_0000);
      chk(q, {16'h0000, d});
      array <= 16'($random(seed));
      run(fsp_pkg::CMD_READ, k[1]);
      av(fsp_pkg::REG_RDATA, 1'b0, 32'h0000_0000);
      chk(q, {16'h0000, array});
    end
    array <= 16'h0020;
    for (int k = 0; k < 4; k++) begin
      reads <= k[0] ? 8'hFF : {7'h00, k[1]};
      fail <= k[1];
      prog <= k[1];
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      run(fsp_pkg::CMD_POLL, k[0]);
      e = exp_res(reads, fail);
      chk({27'h000_0000, q[4:0]}, {27'h000_0000, e == fsp_pkg::RES_DONE, 1'b1, e, 1'b0});
      av(fsp_pkg::REG_CTRL, 1'b0, 32'h0000_0000);
      chk(q, {28'h000_0000, k[0], fsp_pkg::CMD_POLL});
      av(fsp_pkg::REG_SAMPLE, 1'b0, 32'h0000_0000);
      chk(q, {16'h0000, exp_sample(reads, fail, prog)});
    end
    run(fsp_pkg::CMD_RESET, 1'b0);
    chk({16'h0000, i_flash.wr_q}, {16'h0000, fsp_pkg::RESET_CMD});
    av(fsp_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk({31'h0000_0000, q[4]}, 32'h0000_0001);
    av(4'hC, 1'b1, $random(seed));
    av(4'hC, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    give_verdict();
  end
endmodule
